/* verilog/ich_pkg.sv */
`default_nettype none
package ich_pkg;

  // ----------------------------------------------------------------
  // command codes of the bridge device
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_FULL_RESET = 8'hf0;
  localparam logic [7:0] CMD_CONFIG_WRITE = 8'hd2;
  localparam logic [7:0] CMD_POINTER_SELECT = 8'he1;
  localparam logic [7:0] CMD_LINE_RESET = 8'hb4;
  localparam logic [7:0] CMD_LINE_BYTE_WRITE = 8'ha5;
  localparam logic [7:0] CMD_LINE_BYTE_READ = 8'h96;
  localparam logic [7:0] CMD_LINE_SINGLE_SLOT = 8'h87;
  localparam logic [7:0] CMD_SEARCH_STEP = 8'h78;

  // pointer code for the configuration register
  localparam logic [7:0] PTR_CONFIG = 8'hc3;
  // only the direction bit of the search parameter means anything
  localparam logic [7:0] SEARCH_DIR_MASK = 8'h80;

  // ----------------------------------------------------------------
  // slave address
  // ----------------------------------------------------------------
  // fixed upper five address bits, plain default
  localparam logic [4:0] ADDR_UPPER = 5'h06;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;

  // ----------------------------------------------------------------
  // timing: four quarters per scl period
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int STD_BIT_NS = 10000;
  localparam int FAST_BIT_NS = 2500;
  // least times, so round the quarter up
  localparam int STD_Q_INT = (STD_BIT_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FAST_Q_INT = (FAST_BIT_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] STD_QUARTER = 7'(STD_Q_INT);
  localparam logic [6:0] FAST_QUARTER = 7'(FAST_Q_INT);

  // ----------------------------------------------------------------
  // bit slot layout and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [1:0] PH_FALL = 2'h0;
  localparam logic [1:0] PH_SETUP = 2'h1;
  localparam logic [1:0] PH_RISE = 2'h2;
  localparam logic [1:0] PH_SAMPLE = 2'h3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [6:0] RST_QCNT = 7'h00;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_ADDR_W,
    ST_CODE,
    ST_PARAM,
    ST_ADDR_R,
    ST_DATA,
    ST_STOP
  } ich_state_t;

endpackage
`default_nettype wire

/* verilog/ich_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// two flop level synchroniser
// ------------------------------------------------------------------
module ich_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);

  logic meta;
  logic next_meta;
  logic next_sync_out;

  // first flop feeds only the second
  always_comb begin
    next_meta = async_in;
    next_sync_out = meta;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      meta <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta <= next_meta;
      sync_out <= next_sync_out;
    end
  end

endmodule
`default_nettype wire

/* verilog/ich_host.sv */
`timescale 1ns/1ps
`default_nettype none
module ich_host (
  input wire logic clock,
  input wire logic rst,
  input wire logic fast_mode,
  input wire logic addr_select_pin_low,
  input wire logic addr_select_pin_high,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_param,
  input wire logic cmd_read_after,
  input wire logic [7:0] cmd_read_count,
  output logic busy,
  output logic done,
  output logic nack,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ich_pkg::ich_state_t state, next_state;
  logic [1:0] phase, next_phase;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [6:0] qcnt, next_qcnt;
  logic [7:0] shreg, next_shreg;
  logic [7:0] code_q, next_code_q;
  logic [7:0] param_q, next_param_q;
  logic [7:0] rd_left, next_rd_left;
  logic [6:0] addr_q, next_addr_q;
  logic param_en, next_param_en;
  logic want_rd, next_want_rd;
  logic rd_phase, next_rd_phase;
  logic fast_q, next_fast_q;
  logic ack_ok, next_ack_ok;
  logic next_scl_oe;
  logic next_sda_oe;
  logic next_done;
  logic next_nack;
  logic next_rd_valid;
  logic [7:0] next_rd_data;

  logic sda_s;
  logic tick;
  logic is_rx;
  logic [1:0] np;
  logic [6:0] reload;
  logic [6:0] cmd_reload;
  logic cmd_has_param;
  logic [7:0] cmd_param_eff;

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  // sda comes from the wire, so it crosses two flops first
  ich_sync #(
    .RST_VAL(1'b1)
  ) u_sda_sync (
    .clock(clock),
    .rst(rst),
    .async_in(sda_i),
    .sync_out(sda_s)
  );

  // open drain: only ever pull low, the pullup makes the high
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign cmd_ready = (state == ich_pkg::ST_IDLE);
  assign busy = (state != ich_pkg::ST_IDLE);

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  // codes that take one parameter byte; the rest go alone
  always_comb begin
    unique case (cmd_code)
      ich_pkg::CMD_CONFIG_WRITE,
      ich_pkg::CMD_POINTER_SELECT,
      ich_pkg::CMD_LINE_BYTE_WRITE,
      ich_pkg::CMD_LINE_SINGLE_SLOT,
      ich_pkg::CMD_SEARCH_STEP: cmd_has_param = 1'b1;
      default: cmd_has_param = 1'b0;
    endcase
    // search step: lower bits are don't care, send them as zero
    if (cmd_code == ich_pkg::CMD_SEARCH_STEP) begin
      cmd_param_eff = cmd_param & ich_pkg::SEARCH_DIR_MASK;
    end else begin
      cmd_param_eff = cmd_param;
    end
  end

  // ----------------------------------------------------------------
  // quarter-period divider
  // ----------------------------------------------------------------
  // scl is derived here and driven out; no wait on the wire since
  // the device cannot stretch
  always_comb begin
    reload = fast_q ? ich_pkg::FAST_QUARTER - 7'h01 : ich_pkg::STD_QUARTER - 7'h01;
    cmd_reload = fast_mode ? ich_pkg::FAST_QUARTER - 7'h01 : ich_pkg::STD_QUARTER - 7'h01;
    tick = (qcnt == 7'h00) && (state != ich_pkg::ST_IDLE);
    np = phase + 2'h1;
    is_rx = (state == ich_pkg::ST_DATA);
  end

  // ----------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_phase = phase;
    next_bit_cnt = bit_cnt;
    next_qcnt = tick ? reload : qcnt - 7'h01;
    next_shreg = shreg;
    next_code_q = code_q;
    next_param_q = param_q;
    next_rd_left = rd_left;
    next_addr_q = addr_q;
    next_param_en = param_en;
    next_want_rd = want_rd;
    next_rd_phase = rd_phase;
    next_fast_q = fast_q;
    next_ack_ok = ack_ok;
    next_scl_oe = scl_oe;
    next_sda_oe = sda_oe;
    next_done = 1'b0;
    next_nack = nack;
    next_rd_valid = 1'b0;
    next_rd_data = rd_data;
    if (state == ich_pkg::ST_IDLE) begin
      next_qcnt = ich_pkg::RST_QCNT;
      if (cmd_valid) begin
        // latch the whole request so it can change during the transfer
        next_state = ich_pkg::ST_START;
        next_phase = ich_pkg::PH_FALL;
        next_qcnt = cmd_reload;
        next_fast_q = fast_mode;
        next_addr_q = {ich_pkg::ADDR_UPPER, addr_select_pin_high, addr_select_pin_low};
        next_code_q = cmd_code;
        next_param_q = cmd_param_eff;
        next_param_en = cmd_has_param;
        next_want_rd = cmd_read_after;
        next_rd_phase = cmd_read;
        next_rd_left = (cmd_read_count == 8'h00) ? 8'h01 : cmd_read_count;
        next_nack = 1'b0;
      end
    end else if (tick) begin
      next_phase = np;
      unique case (state)
        ich_pkg::ST_START: begin
          // also serves as repeated start: scl low, sda free first
          unique case (np)
            ich_pkg::PH_SETUP: next_sda_oe = 1'b0;
            ich_pkg::PH_RISE: next_scl_oe = 1'b0;
            ich_pkg::PH_SAMPLE: next_sda_oe = 1'b1;
            ich_pkg::PH_FALL: begin
              next_scl_oe = 1'b1;
              next_bit_cnt = 4'h0;
              next_state = rd_phase ? ich_pkg::ST_ADDR_R : ich_pkg::ST_ADDR_W;
              next_shreg = {addr_q, rd_phase ? ich_pkg::RW_READ : ich_pkg::RW_WRITE};
            end
          endcase
        end
        ich_pkg::ST_STOP: begin
          unique case (np)
            ich_pkg::PH_SETUP: next_sda_oe = 1'b1;
            ich_pkg::PH_RISE: next_scl_oe = 1'b0;
            ich_pkg::PH_SAMPLE: next_sda_oe = 1'b0;
            ich_pkg::PH_FALL: begin
              next_state = ich_pkg::ST_IDLE;
              next_done = 1'b1;
            end
          endcase
        end
        ich_pkg::ST_ADDR_W,
        ich_pkg::ST_CODE,
        ich_pkg::ST_PARAM,
        ich_pkg::ST_ADDR_R,
        ich_pkg::ST_DATA: begin
          unique case (np)
            ich_pkg::PH_SETUP: begin
              // sda moves only a quarter after scl fell
              if (bit_cnt == ich_pkg::BIT_ACK) begin
                // ack every read byte but the last
                next_sda_oe = is_rx && (rd_left != 8'h01);
              end else begin
                next_sda_oe = !is_rx && !shreg[7];
              end
            end
            ich_pkg::PH_RISE: next_scl_oe = 1'b0;
            ich_pkg::PH_SAMPLE: begin
              // mid-high sample, well clear of both edges
              if (bit_cnt != ich_pkg::BIT_ACK) begin
                next_shreg = {shreg[6:0], sda_s};
              end else if (!is_rx) begin
                next_ack_ok = !sda_s;
              end
            end
            ich_pkg::PH_FALL: begin
              next_scl_oe = 1'b1;
              if (bit_cnt != ich_pkg::BIT_ACK) begin
                next_bit_cnt = bit_cnt + 4'h1;
              end else begin
                next_bit_cnt = 4'h0;
                unique case (state)
                  ich_pkg::ST_ADDR_W: begin
                    next_state = ich_pkg::ST_CODE;
                    next_shreg = code_q;
                  end
                  ich_pkg::ST_CODE: begin
                    if (param_en) begin
                      next_state = ich_pkg::ST_PARAM;
                      next_shreg = param_q;
                    end else if (want_rd) begin
                      next_state = ich_pkg::ST_START;
                      next_rd_phase = 1'b1;
                    end else begin
                      next_state = ich_pkg::ST_STOP;
                    end
                  end
                  ich_pkg::ST_PARAM: begin
                    next_state = want_rd ? ich_pkg::ST_START : ich_pkg::ST_STOP;
                    next_rd_phase = want_rd;
                  end
                  ich_pkg::ST_ADDR_R: next_state = ich_pkg::ST_DATA;
                  ich_pkg::ST_DATA: begin
                    // each byte is the same pointed register
                    next_rd_data = shreg;
                    next_rd_valid = 1'b1;
                    next_rd_left = rd_left - 8'h01;
                    if (rd_left == 8'h01) begin
                      next_state = ich_pkg::ST_STOP;
                    end
                  end
                  default: next_state = ich_pkg::ST_STOP;
                endcase
                // refused byte: give up and free the bus with a stop
                if (!is_rx && !ack_ok) begin
                  next_state = ich_pkg::ST_STOP;
                  next_rd_phase = 1'b0;
                  next_nack = 1'b1;
                end
              end
            end
          endcase
        end
        default: next_state = ich_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // bus released, no transfer, after reset
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= ich_pkg::ST_IDLE;
      phase <= ich_pkg::PH_FALL;
      bit_cnt <= 4'h0;
      qcnt <= ich_pkg::RST_QCNT;
      shreg <= ich_pkg::RST_BYTE;
      code_q <= ich_pkg::RST_BYTE;
      param_q <= ich_pkg::RST_BYTE;
      rd_left <= ich_pkg::RST_BYTE;
      addr_q <= 7'h00;
      param_en <= 1'b0;
      want_rd <= 1'b0;
      rd_phase <= 1'b0;
      fast_q <= 1'b0;
      ack_ok <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      done <= 1'b0;
      nack <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= ich_pkg::RST_BYTE;
    end else begin
      state <= next_state;
      phase <= next_phase;
      bit_cnt <= next_bit_cnt;
      qcnt <= next_qcnt;
      shreg <= next_shreg;
      code_q <= next_code_q;
      param_q <= next_param_q;
      rd_left <= next_rd_left;
      addr_q <= next_addr_q;
      param_en <= next_param_en;
      want_rd <= next_want_rd;
      rd_phase <= next_rd_phase;
      fast_q <= next_fast_q;
      ack_ok <= next_ack_ok;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
      done <= next_done;
      nack <= next_nack;
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
    end
  end

endmodule
`default_nettype wire

/* testbench/ich_host_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// pin level checks on the host controller
// ----------------------------------------
module ich_host_assertions (
  input wire logic clock,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic done,
  input wire logic nack,
  input wire logic rd_valid,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe
);
  // one domain, so clock and reset are given once
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence s_accept;
    cmd_valid && cmd_ready;
  endsequence
  // sda let go while scl is high is a stop
  sequence s_stop;
    !scl_oe && $fell(sda_oe);
  endsequence
  a_pins_open_drain: assert property (!scl_o && !sda_o)
    else $error("pin drives high");
  a_reset_bus_idle: assert property ($fell(rst) |-> cmd_ready && !scl_oe && !sda_oe && !done && !nack)
    else $error("bus not idle after reset");
  a_start_after_accept: assert property (s_accept |=> !scl_oe throughout (##[40:200] $rose(sda_oe)))
    else $error("no start with scl high");
  a_scl_high_min: assert property ($fell(scl_oe) |-> !scl_oe [*8])
    else $error("scl high phase too short");
  a_sda_hold_low: assert property ($rose(scl_oe) |-> $stable(sda_oe) [*8])
    else $error("sda moved right after scl fell");
  a_stop_then_done: assert property (s_stop |-> ##[14:66] done)
    else $error("no done after stop");
  a_done_bus_idle: assert property (done |-> cmd_ready && !scl_oe && !sda_oe)
    else $error("bus held at done");
  a_read_byte_pulse: assert property (rd_valid |-> !cmd_ready ##1 !rd_valid [*8])
    else $error("read pulse outside byte slot");
  a_nack_cleared: assert property (s_accept |=> !nack)
    else $error("nack kept across accept");
endmodule
bind ich_host ich_host_assertions chk_u (.clock, .rst, .cmd_valid, .cmd_ready, .done, .nack, .rd_valid,
  .scl_o, .scl_oe, .sda_o, .sda_oe);
`default_nettype wire

/* testbench/ich_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// behavioural bridge device on the wires
// ----------------------------------------
module ich_dev_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic addr_select_pin_low,
  input wire logic addr_select_pin_high,
  input wire logic line_busy_flag,
  output logic sda_oe,
  output logic [7:0] last_code,
  output logic [7:0] last_param
);
  int cnt;
  int idx;
  logic act, rd, ok, mack, ptr_cfg;
  logic [7:0] sh, tx, cfg;
  initial begin
    {act, rd, ptr_cfg, sda_oe} = 4'h0;
    {cfg, last_code, last_param} = 24'h0;
  end
  // accept or refuse the byte just shifted in; surplus bytes fall through
  task automatic decide();
    ok = 1'b0;
    if (idx == 0) begin
      ok = sh[7:1] == {ich_pkg::ADDR_UPPER, addr_select_pin_high, addr_select_pin_low};
      rd = sh[0];
    end else if (idx == 1) begin
      ok = sh inside {8'hf0, 8'hd2, 8'he1} || (!line_busy_flag && sh inside {8'hb4, 8'ha5, 8'h96, 8'h87, 8'h78});
      last_code = ok ? sh : last_code;
      ptr_cfg = ptr_cfg && !(ok && sh == 8'hf0);
      cfg = (ok && sh == 8'hf0) ? 8'h00 : cfg;
    end else if (idx == 2) begin
      // only bit 7 of the search byte would matter, so it is merely recorded
      ok = last_code inside {8'hd2, 8'ha5, 8'h87, 8'h78} || (last_code == 8'he1 && sh == ich_pkg::PTR_CONFIG);
      last_param = ok ? sh : last_param;
      cfg = (ok && last_code == 8'hd2) ? sh : cfg;
      ptr_cfg = ptr_cfg || (ok && last_code == 8'he1);
    end
  endtask
  // a start, repeated or not, restarts address reception
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      act = 1'b1;
      cnt = 0;
      idx = 0;
    end
  end
  // a stop sends the port back to idle
  always @(posedge sda) begin
    if (scl === 1'b1) act = 1'b0;
  end
  // bits taken on the rising edge, msb first, master ack in slot nine
  always @(posedge scl) begin
    if (act && cnt < 8) sh = {sh[6:0], sda};
    if (act && cnt == 8) mack = !sda;
    if (act) cnt = cnt + 1;
  end
  // scl is only watched, never held, so any rate works
  always @(negedge scl) begin
    if (act && cnt == 8 && (idx == 0 || !rd)) begin
      decide();
      sda_oe = ok;
    end else if (act && cnt == 9) begin
      cnt = 0;
      idx = idx + 1;
      act = ok && (!rd || idx == 1 || mack);
      tx = ptr_cfg ? cfg : {7'h0c, line_busy_flag};
      sda_oe = act && rd && !tx[7];
    end else if (act && rd && idx > 0) begin
      sda_oe = cnt < 8 && !tx[7 - cnt];
    end
  end
endmodule
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module testbench;
  logic clock, rst, fast_mode, pin_lo, pin_hi, cmd_valid, cmd_read, cmd_read_after, line_busy, dev_lo, dev_hi, pcfg;
  logic [7:0] cmd_code, cmd_param, cmd_read_count, cfg, p;
  logic [7:0] codes [8] = '{8'hf0, 8'hd2, 8'he1, 8'hb4, 8'ha5, 8'h96, 8'h87, 8'h78};
  logic [7:0] got [$];
  wire logic cmd_ready, busy, done, nack, rd_valid, scl_o, scl_oe, sda_o, sda_oe, dev_oe;
  wire logic [7:0] rd_data, last_code, last_param;
  // both lines pulled up, low while any party pulls
  wire logic scl = !scl_oe;
  wire logic sda = !(sda_oe | dev_oe);
  int n_fail = 0;
  int comparisons = 0;
  int n_xfer = 0;
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  ich_host dut_u (.clock(clock), .rst(rst), .fast_mode(fast_mode), .addr_select_pin_low(pin_lo),
    .addr_select_pin_high(pin_hi), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
    .cmd_code(cmd_code), .cmd_param(cmd_param), .cmd_read_after(cmd_read_after), .cmd_read_count(cmd_read_count),
    .busy(busy), .done(done), .nack(nack), .rd_valid(rd_valid), .rd_data(rd_data), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  ich_dev_model dev_u (.scl(scl), .sda(sda), .addr_select_pin_low(dev_lo), .addr_select_pin_high(dev_hi),
    .line_busy_flag(line_busy), .sda_oe(dev_oe), .last_code(last_code), .last_param(last_param));
  // ----------------------------------------
  // expectations and transfer driver
  // ----------------------------------------
  // four quarters per bit, nine bits per byte, plus start, stop, restart
  function automatic int bus_cycles(input logic fm, input int bytes, input int rs);
    return (fm ? ich_pkg::FAST_Q_INT : ich_pkg::STD_Q_INT) * (8 + 36 * bytes + 4 * rs);
  endfunction
  function automatic logic [7:0] exp_reg();
    return pcfg ? cfg : {7'h0c, line_busy};
  endfunction
  task automatic results();
    if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // entered at a falling edge, so back to back requests land in the done cycle
  task automatic xfer(input logic rd, input logic [7:0] code, input logic [7:0] prm, input logic ra,
      input logic [7:0] cnt, input logic exp_nack);
    int n;
    int nb;
    int nbus;
    logic fm;
    // standard rate on every third transfer only: keeps the run short, both rates still seen
    fm = (n_xfer % 3 != 0);
    n_xfer++;
    fast_mode = fm;
    {cmd_read, cmd_code, cmd_param, cmd_read_after, cmd_read_count} = {rd, code, prm, ra, cnt};
    cmd_valid = 1'b1;
    @(negedge clock);
    cmd_valid = 1'b0;
    `CHK("busy", 1'b1, busy)
    got.delete();
    n = 0;
    while (done !== 1'b1 && n < 60000) begin
      @(negedge clock);
      n++;
      if (rd_valid === 1'b1) got.push_back(rd_data);
    end
    if (n >= 60000) begin
      n_fail++;
      results();
    end
    `CHK("nack", exp_nack, nack)
    `CHK("busy_end", 1'b0, busy)
    if (!exp_nack) begin
      nb = (cnt == 8'h00) ? 1 : int'(cnt);
      nbus = rd ? 1 + nb : 2 + int'(code inside {8'hd2, 8'he1, 8'ha5, 8'h87, 8'h78}) + (ra ? 1 + nb : 0);
      `CHK("cycles", bus_cycles(fm, nbus, int'(ra && !rd)), n)
      `CHK("bytes", (rd || ra) ? nb : 0, got.size())
      if (!rd) begin
        `CHK("code", code, last_code)
        if (code inside {8'ha5, 8'h87, 8'h78}) `CHK("param", (code == 8'h78) ? (prm & 8'h80) : prm, last_param)
        if (code == 8'hf0) {pcfg, cfg} = 9'h000;
        if (code == 8'hd2) cfg = prm;
        if (code == 8'he1) pcfg = 1'b1;
      end
      foreach (got[i]) `CHK("rd_data", exp_reg(), got[i])
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'ha9d4753f));
    rst = 1'b1;
    {fast_mode, cmd_valid, cmd_read, cmd_read_after, line_busy, pcfg} = 6'h00;
    {cmd_code, cmd_param, cmd_read_count, cfg} = 32'h0;
    {dev_hi, dev_lo} = 2'($urandom);
    {pin_hi, pin_lo} = {dev_hi, dev_lo};
    repeat (4) @(negedge clock);
    rst = 1'b0;
    `CHK("idle", 3'b100, {cmd_ready, scl_oe, sda_oe})
    // every command, each read back over a repeated start
    foreach (codes[i]) begin
      p = (codes[i] == 8'he1) ? ich_pkg::PTR_CONFIG : 8'($urandom);
      xfer(1'b0, codes[i], p, 1'b1, 8'($urandom_range(3)), 1'b0);
    end
    // line commands refused while the line is busy, then a bad pointer and an unknown code
    line_busy = 1'b1;
    for (int i = 3; i < 8; i++) xfer(1'b0, codes[i], 8'($urandom), 1'b1, 8'h01, 1'b1);
    line_busy = 1'b0;
    xfer(1'b0, 8'he1, 8'he5, 1'b0, 8'h01, 1'b1);
    xfer(1'b0, 8'h3c, 8'h00, 1'b0, 8'h01, 1'b1);
    // all four straps; only the device's own address is answered
    for (int i = 0; i < 4; i++) begin
      {pin_hi, pin_lo} = 2'(i);
      xfer(1'b1, 8'h00, 8'h00, 1'b0, 8'h02, {pin_hi, pin_lo} != {dev_hi, dev_lo});
    end
    {pin_hi, pin_lo} = {dev_hi, dev_lo};
    // reset in mid address byte must free the bus at once
    fast_mode = 1'b1;
    cmd_read = 1'b1;
    cmd_valid = 1'b1;
    @(negedge clock);
    cmd_valid = 1'b0;
    repeat (200) @(negedge clock);
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    `CHK("abort", 3'b100, {cmd_ready, scl_oe, sda_oe})
    repeat (3) xfer(1'b1, 8'h00, 8'h00, 1'b0, 8'($urandom_range(4)), 1'b0);
    results();
  end
endmodule
`default_nettype wire
